/* meter_result_map.svh */
`ifndef METER_RESULT_MAP_SVH
`define METER_RESULT_MAP_SVH

// Register byte offsets, one aligned word each
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define MASK_OFS 8'h08
`define DIGITS_OFS 8'h0c
`define STATE_OFS 8'h10

// Control fields and reset value
`define CTRL_MANUAL_BIT 0
`define CTRL_BEEP_BIT 1
`define CTRL_W 2
`define CTRL_RST 2'h0

// Event bits shared by status and mask
`define EV_DONE 0
`define EV_FAULT 1
`define EV_SETERR 2
`define EV_GATE 3
`define EV_W 4
`define EV_RST 4'h0

// Digit layout and line codes
`define DIGIT_COUNT 4
`define DIGIT_W 4
`define LINES_W 16
`define CODE_OVER 4'h6
`define CODE_FAULT 4'h0
`define LINES_IDLE 16'hffff

// Timing, times in their own units
`define MS_NS 1000000
`define CLK_PERIOD_NS 40
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define GATE_SETUP_MS 8'h05
`define STROBE_LOW_MS 8'h02
`define BEEP_HALF_MS 16'h00fa

`endif

/* meter_result_pkg.sv */
`include "meter_result_map.svh"
package meter_result_pkg;

  // Strobe sequencer, Gray along idle, setup, low
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SETUP = 2'h1,
    ST_LOW = 2'h3
  } strobe_state_t;

  // One measurement from the converter side
  typedef struct packed {
    logic [`DIGIT_COUNT-1:0][`DIGIT_W-1:0] bcd;
    logic overload;
  } meas_t;

  // Comparison output lines, low means transistor on
  typedef struct packed {
    logic above_n;
    logic within_n;
    logic below_n;
  } cmp_lines_t;

endpackage

/* beep_pacer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "meter_result_map.svh"

// Millisecond tick divider and periodic beep phase
module beep_pacer #(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  output logic ms_tick,
  output logic beep_phase
);

  logic [31:0] div_q; // Cycle count inside one ms
  logic [15:0] half_q; // Ms count inside one beep half period
  logic tick_q;
  logic phase_q;

  // Divider; restart realigns so a window starts on a whole ms
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (div_q == 32'(CYC_PER_MS - 1)) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Beep phase toggles every half period; restart jitter is harmless
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_q <= 16'h0000;
      phase_q <= 1'b0;
    end else if (tick_q) begin
      if (half_q == `BEEP_HALF_MS - 16'h0001) begin
        half_q <= 16'h0000;
        phase_q <= ~phase_q;
      end else begin
        half_q <= half_q + 16'h0001;
      end
    end
  end

  assign ms_tick = tick_q;
  assign beep_phase = phase_q;

endmodule
`default_nettype wire

/* meter_result_parallel_output.sv */
`timescale 1ns/1ns
`default_nettype none
`include "meter_result_map.svh"
module meter_result_parallel_output
  import meter_result_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic meas_valid,
  input wire meas_t meas,
  input wire logic cmp_above_in,
  input wire logic cmp_below_in,
  input wire logic setting_invalid,
  input wire logic source_fault_in,
  input wire logic manual_output_gate,
  output logic [`LINES_W-1:0] digit_lines,
  output logic source_fault_flag_n,
  output logic conv_done_line,
  output logic above_limit_out_n,
  output logic within_limit_out_n,
  output logic below_limit_out_n,
  output logic led_above,
  output logic led_within,
  output logic led_below,
  output logic beeper,
  output logic irq
);

  localparam int SETUP_CYC = int'(`GATE_SETUP_MS) * CYC_PER_MS;

  // Bus slave state
  logic take; // Address phase accepted
  logic wr_q; // Write data phase pending
  logic [7:0] addr_q; // Latched byte offset
  logic [31:0] rd_d;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  // Software control and events
  logic [`CTRL_W-1:0] ctrl_q;
  logic [`EV_W-1:0] status_q;
  logic [`EV_W-1:0] mask_q;
  logic [`EV_W-1:0] ev; // One-cycle event pulses
  logic irq_q;
  logic manual; // Manual comparison mode
  logic beep_sw; // Beeper switch

  // Strobe sequencer
  strobe_state_t state_q, state_d;
  logic [7:0] ms_cnt_q;
  logic ms_tick;
  logic beep_phase;
  logic start; // New measurement accepted by sequencer
  logic rise_now; // Last cycle of strobe low
  logic gate_ok_q; // Gate held low over the whole window
  logic gate_prev_q;
  logic gate_moved_q; // Gate changed inside the window

  // Digit path
  logic [`LINES_W-1:0] code_d; // Encoded lines of incoming value
  logic [`LINES_W-1:0] pend_q; // Value waiting for the strobe rise
  logic [`LINES_W-1:0] digit_q;
  logic done_line_q;
  logic fault_n_q;

  // Comparison path
  logic above_q, below_q, over_q; // Latest measurement outcome
  logic res_above, res_below, res_within;
  logic show, cancel, ext_on;
  cmp_lines_t cmp_d, cmp_q;
  logic [2:0] led_q;
  logic beep_q;
  logic fault_prev_q, inv_prev_q;

  assign manual = ctrl_q[`CTRL_MANUAL_BIT];
  assign beep_sw = ctrl_q[`CTRL_BEEP_BIT];

  // Zero-wait slave: only single word transfers are expected
  assign take = hsel & htrans[1] & hready;

  // Address phase capture and read data prepared for the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (take) begin
        addr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata_q <= rd_d;
      end
    end
  end

  // Read mux; unmapped offsets read as zero with OKAY
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (haddr[7:0])
      `CTRL_OFS: rd_d[`CTRL_W-1:0] = ctrl_q;
      `STATUS_OFS: rd_d[`EV_W-1:0] = status_q;
      `MASK_OFS: rd_d[`EV_W-1:0] = mask_q;
      `DIGITS_OFS: begin
        rd_d[`LINES_W-1:0] = digit_q;
        rd_d[16] = fault_n_q;
        rd_d[17] = done_line_q;
      end
      `STATE_OFS: begin
        rd_d[2:0] = cmp_q;
        rd_d[5:3] = led_q;
        rd_d[6] = beep_q;
        rd_d[9:8] = state_q;
        rd_d[10] = gate_ok_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Control register write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_q && addr_q == `CTRL_OFS) begin
      ctrl_q <= hwdata[`CTRL_W-1:0];
    end
  end

  // Mask register write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= `EV_RST;
    end else if (wr_q && addr_q == `MASK_OFS) begin
      mask_q <= hwdata[`EV_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= `EV_RST;
    end else if (wr_q && addr_q == `STATUS_OFS) begin
      status_q <= (status_q & ~hwdata[`EV_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Event sources
  always_comb begin
    ev = `EV_RST;
    ev[`EV_DONE] = rise_now;
    ev[`EV_FAULT] = source_fault_in & ~fault_prev_q;
    ev[`EV_SETERR] = setting_invalid & ~inv_prev_q;
    ev[`EV_GATE] = rise_now & gate_moved_q & manual;
  end

  // Edge history for event detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_prev_q <= 1'b0;
      inv_prev_q <= 1'b0;
    end else begin
      fault_prev_q <= source_fault_in;
      inv_prev_q <= setting_invalid;
    end
  end

  beep_pacer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_pacer (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(start),
    .ms_tick(ms_tick),
    .beep_phase(beep_phase)
  );

  // Measurements arriving mid-sequence skip the digit port
  assign start = meas_valid && state_q == ST_IDLE;
  assign rise_now = state_q == ST_LOW && ms_tick &&
                    ms_cnt_q == `STROBE_LOW_MS - 8'h01;

  // Sequencer: gate window, then strobe low, then rise
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_SETUP;
      ST_SETUP: begin
        if (ms_tick && ms_cnt_q == `GATE_SETUP_MS - 8'h01) begin
          state_d = ST_LOW;
        end
      end
      ST_LOW: if (rise_now) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State and ms counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ms_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        ms_cnt_q <= 8'h00;
      end else if (ms_tick) begin
        ms_cnt_q <= ms_cnt_q + 8'h01;
      end
    end
  end

  // Gate watch across the window before the strobe falls
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gate_ok_q <= 1'b0;
      gate_prev_q <= 1'b1;
      gate_moved_q <= 1'b0;
    end else if (start) begin
      gate_ok_q <= 1'b1;
      gate_prev_q <= manual_output_gate;
      gate_moved_q <= 1'b0;
    end else if (state_q == ST_SETUP) begin
      gate_prev_q <= manual_output_gate;
      if (manual_output_gate) begin
        gate_ok_q <= 1'b0;
      end
      if (manual_output_gate != gate_prev_q) begin
        gate_moved_q <= 1'b1;
      end
    end
  end

  // Per digit encoding, index 3 is thousands on the top lines
  for (genvar g = 0; g < `DIGIT_COUNT; g++) begin : g_digit
    always_comb begin
      if (source_fault_in) begin
        code_d[g*`DIGIT_W +: `DIGIT_W] = `CODE_FAULT;
      end else if (meas.overload) begin
        code_d[g*`DIGIT_W +: `DIGIT_W] = `CODE_OVER;
      end else begin
        code_d[g*`DIGIT_W +: `DIGIT_W] = ~meas.bcd[g];
      end
    end
  end

  // Pending value held until the strobe rises
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= `LINES_IDLE;
    end else if (start) begin
      pend_q <= code_d;
    end
  end

  // Digit lines move only on a qualifying rise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      digit_q <= `LINES_IDLE;
    end else if (rise_now && (!manual || gate_ok_q)) begin
      digit_q <= pend_q;
    end
  end

  // Strobe and fault lines; fault ignores strobe timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_line_q <= 1'b1;
      fault_n_q <= 1'b1;
    end else begin
      done_line_q <= state_d != ST_LOW;
      fault_n_q <= ~source_fault_in;
    end
  end

  // Outcome of each new measurement, no trigger needed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      above_q <= 1'b0;
      below_q <= 1'b0;
      over_q <= 1'b0;
    end else if (meas_valid) begin
      above_q <= cmp_above_in;
      below_q <= cmp_below_in;
      over_q <= meas.overload;
    end
  end

  // Priority: overload forces above, then above, then below
  assign res_above = over_q | above_q;
  assign res_below = ~res_above & below_q;
  assign res_within = ~res_above & ~res_below;
  // Manual mode shows results only while the gate is shorted low
  assign show = ~manual | ~manual_output_gate;
  assign cancel = source_fault_in | setting_invalid;
  assign ext_on = show & ~cancel;

  // One line low per outcome, all released when off
  always_comb begin
    cmp_d.above_n = ~(ext_on & res_above);
    cmp_d.within_n = ~(ext_on & res_within);
    cmp_d.below_n = ~(ext_on & res_below);
  end

  // Registered comparison lines, LEDs and beeper
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_q <= 3'h7;
      led_q <= 3'h0;
      beep_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      led_q <= ~cmp_d;
      // Invalid setting beeps periodically in either mode
      beep_q <= beep_sw & ((ext_on & res_within) |
                (setting_invalid & beep_phase));
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign digit_lines = digit_q;
  assign source_fault_flag_n = fault_n_q;
  assign conv_done_line = done_line_q;
  assign above_limit_out_n = cmp_q.above_n;
  assign within_limit_out_n = cmp_q.within_n;
  assign below_limit_out_n = cmp_q.below_n;
  assign led_above = led_q[2];
  assign led_within = led_q[1];
  assign led_below = led_q[0];
  assign beeper = beep_q;
  assign irq = irq_q;

  // Helper count of cycles spent in the gate window
  logic [31:0] setup_cyc_q;
  always_ff @(posedge ref_clk) begin
    if (rst || state_q != ST_SETUP) begin
      setup_cyc_q <= 32'h0000_0000;
    end else begin
      setup_cyc_q <= setup_cyc_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_auto_within;
    meas_valid && !manual && !cmp_above_in && !cmp_below_in &&
      !meas.overload && !cancel ##1 !cancel;
  endsequence

  auto_update_a: assert property (s_auto_within |=> !within_limit_out_n)
    else $error("within line not set after measurement");
  beep_within_a: assert property (ext_on && res_within && beep_sw |=> beeper)
    else $error("beeper silent on within result");
  beep_off_sw_a: assert property (!beep_sw |=> !beeper)
    else $error("beeper on with switch off");
  cmp_onehot_a: assert property (ext_on |=> $onehot(~cmp_q))
    else $error("comparison lines not one-hot");
  digit_hold_a: assert property (!rise_now |=> $stable(digit_lines))
    else $error("digits moved off the strobe rise");
  strobe_rise_a: assert property (rise_now |=> $rose(conv_done_line))
    else $error("strobe did not rise with digit update");
  fault_flag_a: assert property (source_fault_in |=> !source_fault_flag_n)
    else $error("fault flag not low");
  setup_len_a: assert property (state_q == ST_SETUP && state_d == ST_LOW
    |-> setup_cyc_q == 32'(SETUP_CYC))
    else $error("gate window length wrong");
  manual_keep_a: assert property (rise_now && manual && !gate_ok_q
    |=> $stable(digit_lines))
    else $error("manual digits changed with gate high");
  digit_code_a: assert property (start && !source_fault_in &&
    !meas.overload |=> pend_q == ~$past(meas.bcd))
    else $error("digit code not inverted value");
  over_code_a: assert property (start && !source_fault_in && meas.overload
    |=> pend_q == {`DIGIT_COUNT{`CODE_OVER}})
    else $error("overload code wrong");
  fault_code_a: assert property (start && source_fault_in
    |=> pend_q == {`DIGIT_COUNT{`CODE_FAULT}})
    else $error("fault code wrong");
  manual_off_a: assert property (manual && manual_output_gate && !setting_invalid
    |=> cmp_q == 3'h7 && led_q == 3'h0 && !beeper)
    else $error("manual mode output while gate open");
  over_above_a: assert property (ext_on && over_q |=> !above_limit_out_n)
    else $error("overload not reported above");
  invalid_off_a: assert property (setting_invalid
    |=> cmp_q == 3'h7 && led_q == 3'h0)
    else $error("outputs live with invalid setting");
  fault_cancel_a: assert property (source_fault_in |=> cmp_q == 3'h7)
    else $error("outputs live with source missing");

endmodule
`default_nettype wire

/* meter_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Far-side controller: reads digits at each strobe rise, drives the gate
module meter_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic meas_valid,
  input wire logic conv_done_line,
  input wire logic [15:0] digit_lines,
  input wire logic gate_req,
  output logic manual_output_gate,
  output logic [15:0] cap_q,
  output logic [7:0] frames_q
);
  logic strobe_q; // Strobe level one edge back
  logic busy_q; // A frame is running

  // Frame tracking, a frame closes at the strobe rise
  always_ff @(posedge ref_clk) begin
    strobe_q <= conv_done_line;
    if (rst) begin
      busy_q <= 1'b0;
    end else if (!strobe_q && conv_done_line) begin
      busy_q <= 1'b0;
    end else if (meas_valid) begin
      busy_q <= 1'b1;
    end
  end

  // Gate moves only between frames, so it never shifts inside the window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      manual_output_gate <= 1'b1;
    end else if (!busy_q) begin
      manual_output_gate <= gate_req;
    end
  end

  // Digits are taken once the strobe has risen, never earlier
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_q <= 16'hffff;
      frames_q <= 8'h00;
    end else if (!strobe_q && conv_done_line) begin
      cap_q <= digit_lines;
      frames_q <= frames_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "meter_result_map.svh"
// Self-checking bench for the result output stage
module tb
  import meter_result_pkg::*;
;
  localparam int unsigned CPM = 10; // Short millisecond keeps frames brief
  typedef struct packed {
    logic [15:0] bcd;
    logic ov, ab, be, flt;
    logic [15:0] dig;
    logic [2:0] oc;
    logic bp;
  } row_t;
  logic ref_clk, rst, hsel, hwrite, hready, meas_valid, gate_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cmp, leds;
  logic hreadyout, hresp, cmp_above_in, cmp_below_in;
  logic setting_invalid, source_fault_in, manual_output_gate;
  logic source_fault_flag_n, conv_done_line, beeper, irq;
  logic above_limit_out_n, within_limit_out_n, below_limit_out_n;
  logic led_above, led_within, led_below;
  logic [15:0] digit_lines, cap_q, prev;
  logic [7:0] frames_q;
  meas_t meas;
  int errors, checked, n_hi;
  // Ordinary cases, auto mode with beeper switch on
  row_t rows [6] = '{
    '{16'h1234, 1'b0, 1'b0, 1'b0, 1'b0, 16'hedcb, 3'h5, 1'b1},
    '{16'h9870, 1'b0, 1'b1, 1'b0, 1'b0, 16'h678f, 3'h3, 1'b0},
    '{16'h0005, 1'b0, 1'b0, 1'b1, 1'b0, 16'hfffa, 3'h6, 1'b0},
    '{16'h0000, 1'b1, 1'b0, 1'b1, 1'b0, 16'h6666, 3'h3, 1'b0},
    '{16'h1234, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 3'h7, 1'b0},
    '{16'h3500, 1'b0, 1'b0, 1'b0, 1'b0, 16'hcaff, 3'h5, 1'b1}};

  assign hready = hreadyout; // Single slave drives the bus ready
  assign cmp = {above_limit_out_n, within_limit_out_n, below_limit_out_n};
  assign leds = {led_above, led_within, led_below};

  meter_result_parallel_output #(.CYC_PER_MS(CPM)) DUT (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .meas_valid(meas_valid), .meas(meas),
    .cmp_above_in(cmp_above_in), .cmp_below_in(cmp_below_in),
    .setting_invalid(setting_invalid), .source_fault_in(source_fault_in),
    .manual_output_gate(manual_output_gate), .digit_lines(digit_lines),
    .source_fault_flag_n(source_fault_flag_n),
    .conv_done_line(conv_done_line), .above_limit_out_n(above_limit_out_n),
    .within_limit_out_n(within_limit_out_n),
    .below_limit_out_n(below_limit_out_n), .led_above(led_above),
    .led_within(led_within), .led_below(led_below), .beeper(beeper),
    .irq(irq));

  meter_ctrl_model ctrl (
    .ref_clk(ref_clk), .rst(rst), .meas_valid(meas_valid),
    .conv_done_line(conv_done_line), .digit_lines(digit_lines),
    .gate_req(gate_req), .manual_output_gate(manual_output_gate),
    .cap_q(cap_q), .frames_q(frames_q));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer, held until ready is seen at each phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
    check("hresp", hresp, 1'b0);
  endtask

  // Read and compare a register
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check("register", rd, exp);
  endtask

  // One measurement frame; digits must hold until the strobe rises
  task automatic send(input logic [15:0] bcd, input logic ov, ab, be);
    int n;
    logic [7:0] f0;
    f0 = frames_q;
    n = 0;
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas <= {bcd, ov};
    cmp_above_in <= ab;
    cmp_below_in <= be;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    while (conv_done_line !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check("held", digit_lines, prev);
    while (frames_q === f0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check("frame", frames_q, 8'(f0 + 8'h01));
    repeat (2) @(posedge ref_clk);
  endtask

  // Reset with the idle levels checked while it is held
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    check("rst_dig", digit_lines, 16'hffff);
    check("rst_lines", {source_fault_flag_n, conv_done_line, cmp}, 5'h1f);
    check("rst_misc", {leds, beeper, irq, hreadyout}, 6'h01);
    rst <= 1'b0;
    prev = 16'hffff;
  endtask

  // Verdict, the single end of the run
  task automatic close_out;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Watchdog, far beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    {rst, hsel, hwrite, meas_valid, cmp_above_in, cmp_below_in} = '0;
    {setting_invalid, source_fault_in} = '0;
    {haddr, hwdata, htrans, meas} = '0;
    hsize = 3'h2;
    gate_req = 1'b1;
    errors = 0;
    checked = 0;
    do_reset(10);
    rd_chk(`CTRL_OFS, 32'h0000_0000);
    rd_chk(`MASK_OFS, 32'h0000_0000);
    ahb(1'b1, `CTRL_OFS, 32'h0000_0002);
    rd_chk(`CTRL_OFS, 32'h0000_0002);
    ahb(1'b1, 8'h24, 32'hffff_ffff);
    rd_chk(`CTRL_OFS, 32'h0000_0002);
    rd_chk(8'h20, 32'h0000_0000);
    foreach (rows[i]) begin
      source_fault_in <= rows[i].flt;
      repeat (3) @(posedge ref_clk);
      check("flag", source_fault_flag_n, 1'(~rows[i].flt));
      send(rows[i].bcd, rows[i].ov, rows[i].ab, rows[i].be);
      check("cap", cap_q, rows[i].dig);
      check("dig", digit_lines, rows[i].dig);
      check("cmp", cmp, rows[i].oc);
      check("leds", leds, 3'(~rows[i].oc));
      check("beep", beeper, rows[i].bp);
      prev = rows[i].dig;
    end
    // Manual mode, gate open: nothing shown, digits kept
    ahb(1'b1, `CTRL_OFS, 32'h0000_0003);
    send(16'h4321, 1'b0, 1'b0, 1'b0);
    check("man_hold", digit_lines, prev);
    check("man_off", {cmp, leds, beeper}, 7'h70);
    // Gate held low across the window
    gate_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    send(16'h4321, 1'b0, 1'b0, 1'b0);
    check("man_dig", digit_lines, 16'hbcde);
    check("man_on", {cmp, beeper}, 4'hb);
    prev = 16'hbcde;
    // Invalid settings with the beeper switch off
    ahb(1'b1, `CTRL_OFS, 32'h0000_0000);
    setting_invalid <= 1'b1;
    send(16'h0001, 1'b0, 1'b0, 1'b0);
    check("inv_off", {cmp, leds}, 6'h38);
    check("inv_beep", beeper, 1'b0);
    setting_invalid <= 1'b0;
    prev = 16'hfffe;
    send(16'h0002, 1'b0, 1'b0, 1'b0);
    check("sw_off", {cmp, beeper}, 4'ha);
    // Invalid settings with the switch on: beeper pulses by itself
    ahb(1'b1, `CTRL_OFS, 32'h0000_0002);
    setting_invalid <= 1'b1;
    n_hi = 0;
    repeat (6000) begin
      @(posedge ref_clk);
      n_hi += beeper;
    end
    check("inv_pulse", n_hi > 1000 && n_hi < 5000, 1'b1);
    check("inv_lines", cmp, 3'h7);
    setting_invalid <= 1'b0;
    // Sticky status, mask and level interrupt
    rd_chk(`STATUS_OFS, 32'h0000_0007);
    check("irq_masked", irq, 1'b0);
    ahb(1'b1, `MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    check("irq_on", irq, 1'b1);
    ahb(1'b1, `STATUS_OFS, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    check("irq_off", irq, 1'b0);
    rd_chk(`STATUS_OFS, 32'h0000_0000);
    // Second reset in mid-run
    do_reset(2);
    rd_chk(`MASK_OFS, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
